// ==== pwm_pkg.sv ====
// Shared constants and carrier types for the dual channel modulator
package pwm_pkg;

   // ***************************************************************
   // Bus geometry
   // ***************************************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte offsets on the register bus
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'hBC;
   localparam logic [ADDR_W-1:0] OFS_RELOAD  = 8'hC0;
   localparam logic [ADDR_W-1:0] OFS_CMP0    = 8'hC4;
   localparam logic [ADDR_W-1:0] OFS_CMP1    = 8'hC8;

   // ***************************************************************
   // Modulator sizes and special values
   // ***************************************************************
   localparam int         NUM_CH     = 2;
   localparam int         CNT_W      = 8;
   localparam logic [7:0] CNT_MAX    = 8'hFE;  // Counter runs 0..254
   localparam logic [7:0] CNT_ZERO   = 8'h00;
   localparam logic [7:0] PRESC_WRAP = 8'hFF;  // Prescaler terminal count
   localparam logic [7:0] CMP_LOW    = 8'h00;  // Output held low
   localparam logic [7:0] CMP_HIGH   = 8'hFF;  // Output held high
   localparam int         TICK_DIV   = 2;      // Clocks per prescaler step

   // Reset values
   localparam logic [7:0] RELOAD_RESET = 8'h00;
   localparam logic [7:0] CMP_RESET    = 8'h00;

   // Control register field positions
   localparam int CTRL_OVF_BIT = 3;
   localparam int CTRL_RUN_BIT = 2;
   localparam int CTRL_PE1_BIT = 1;
   localparam int CTRL_PE0_BIT = 0;

   // ***************************************************************
   // Carrier types
   // ***************************************************************
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } apb_req_s;

   // Control bits in register order, bit 3 down to bit 0
   typedef struct packed {
      logic       counter_overflow_flag;
      logic       counter_enable_clear_n;
      logic [1:0] pin_drive_enable;
   } ctrl_s;

   localparam ctrl_s CTRL_RESET = 4'h0;

endpackage

// ==== dual_channel_pwm_unit.sv ====
// Two channel pulse width modulator with an APB register slave
//
// Function
// - Prescaler reloads complement on overflow, reset, clear
// - Prescaler divides by reload plus one
// - Shared counter counts 0 to 254, wraps
// - Counter equal compare drives output low
// - Counter zero drives output high, except 00H
// - Compare 00H always low, FFH always high
// - Counter runs on enable; pins gated separately
// - Chip reset clears whole modulator
// - Idle mode keeps modulator running normally
// - Power-down freezes state, resumes afterwards
// - Clear low zeroes counter, reloads, outputs high except 00H
// - Period is oscillator over 510 times reload+1
// - High/low ratio is compare over 255-compare
// - Disabled pin released; counter usable as timer
// - Overflow flag set by hardware, software clears
// - Control bits: enable bit2, pin1 bit1, pin0 bit0
`timescale 1ns/1ps

module dual_channel_pwm_unit
#(
   parameter int NUM_CH = pwm_pkg::NUM_CH
)
(
   input  wire logic                      core_clk_i,
   input  wire logic                      resetn_i,
   input  wire logic                      power_down_i,
   input  wire pwm_pkg::apb_req_s         apb_req_i,
   output logic [pwm_pkg::DATA_W-1:0]     prdata_o,
   output logic                           pready_o,
   output logic                           pslverr_o,
   output logic [NUM_CH-1:0]              pwm_pin_o,
   output logic [NUM_CH-1:0]              pwm_pin_oe_o
);
   import pwm_pkg::*;

   // ***************************************************************
   // Declarations
   // ***************************************************************
   localparam int DIV_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
   localparam logic [ADDR_W-1:0] OFS_CMP [2] = '{OFS_CMP0, OFS_CMP1};

   ctrl_s              ctrl_reg;
   logic [7:0]         reload_reg;
   logic [7:0]         cmp_reg [NUM_CH];
   logic [DIV_W-1:0]   div_reg;
   logic [7:0]         presc_reg;
   logic [CNT_W-1:0]   cnt_reg;
   logic [NUM_CH-1:0]  level_reg;
   logic [NUM_CH-1:0]  oe_reg;
   logic [DATA_W-1:0]  prdata_reg;
   logic               pready_reg;
   logic               pslverr_reg;

   logic               setup_phase;
   logic               wr_en;
   logic               rd_setup;
   logic               addr_hit;
   logic               run;
   logic               tick;
   logic               step;
   logic               wrap;
   logic [DATA_W-1:0]  rd_next;

   // ***************************************************************
   // APB slave
   // ***************************************************************

   // Bus phases; zero wait states, the write lands at the access edge
   assign setup_phase = apb_req_i.psel & ~apb_req_i.penable;
   assign wr_en       = apb_req_i.psel & apb_req_i.penable &
                        apb_req_i.pwrite & pready_reg;
   assign rd_setup    = setup_phase & ~apb_req_i.pwrite;

   // Address decode and read mux, unmapped words read as zero
   always_comb
   begin
      addr_hit = 1'b1;
      rd_next  = '0;
      unique case (apb_req_i.paddr)
         OFS_CONTROL: rd_next = {{(DATA_W-4){1'b0}}, ctrl_reg};
         OFS_RELOAD:  rd_next = {{(DATA_W-8){1'b0}}, reload_reg};
         OFS_CMP0:    rd_next = {{(DATA_W-8){1'b0}}, cmp_reg[0]};
         OFS_CMP1:    rd_next = {{(DATA_W-8){1'b0}}, cmp_reg[NUM_CH-1]};
         default:     addr_hit = 1'b0;
      endcase
   end

   // Handshake flops; pready rises for exactly the access cycle
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         pready_reg  <= setup_phase;
         pslverr_reg <= setup_phase & ~addr_hit;
      end
   end

   // Read data captured in setup so it comes straight from a flop
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         prdata_reg <= '0;
      else if (rd_setup)
         prdata_reg <= rd_next;
   end

   // Reload and compare registers
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         reload_reg <= RELOAD_RESET;
         for (int ch = 0; ch < NUM_CH; ch++)
            cmp_reg[ch] <= CMP_RESET;
      end
      else if (wr_en)
      begin
         if (apb_req_i.paddr == OFS_RELOAD)
            reload_reg <= apb_req_i.pwdata[7:0];
         for (int ch = 0; ch < NUM_CH; ch++)
            if (apb_req_i.paddr == OFS_CMP[ch])
               cmp_reg[ch] <= apb_req_i.pwdata[7:0];
      end
   end

   // Control register; the overflow event beats a clearing write
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         ctrl_reg <= CTRL_RESET;
      else
      begin
         if (wr_en && apb_req_i.paddr == OFS_CONTROL)
         begin
            ctrl_reg.counter_enable_clear_n <=
               apb_req_i.pwdata[CTRL_RUN_BIT];
            ctrl_reg.pin_drive_enable <=
               {apb_req_i.pwdata[CTRL_PE1_BIT],
                apb_req_i.pwdata[CTRL_PE0_BIT]};
            if (!apb_req_i.pwdata[CTRL_OVF_BIT])
               ctrl_reg.counter_overflow_flag <= 1'b0;
         end
         if (wrap)
            ctrl_reg.counter_overflow_flag <= 1'b1;
      end
   end

   // ***************************************************************
   // Prescaler and counter
   // ***************************************************************

   // Idle mode has no input here: the block simply keeps counting
   // no idle gating
   assign run  = ctrl_reg.counter_enable_clear_n & ~power_down_i;
   assign tick = run & (div_reg == DIV_LAST);
   // divide by reload plus one, sets the period
   assign step = tick & (presc_reg == PRESC_WRAP);
   assign wrap = step & (cnt_reg == CNT_MAX);

   // Oscillator divider, held at zero while the counter is cleared
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         div_reg <= '0;
      else if (power_down_i)
         div_reg <= div_reg;
      else if (!ctrl_reg.counter_enable_clear_n)
         div_reg <= '0;
      else if (div_reg == DIV_LAST)
         div_reg <= '0;
      else
         div_reg <= div_reg + DIV_W'(1);
   end

   // Prescaler counts up from the complement to FFh, then reloads
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         presc_reg <= ~RELOAD_RESET;
      else if (power_down_i)
         presc_reg <= presc_reg;
      else if (!ctrl_reg.counter_enable_clear_n)
         presc_reg <= ~reload_reg;
      // reload at terminal count, covers overflow
      else if (step)
         presc_reg <= ~reload_reg;
      else if (tick)
         presc_reg <= presc_reg + 8'h01;
   end

   // Shared counter; keeps running with both pins released
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         cnt_reg <= CNT_ZERO;
      else if (power_down_i)
         cnt_reg <= cnt_reg;
      else if (!ctrl_reg.counter_enable_clear_n)
         cnt_reg <= CNT_ZERO;
      else if (wrap)
         cnt_reg <= CNT_ZERO;
      else if (step)
         cnt_reg <= cnt_reg + 8'h01;
   end

   // ***************************************************************
   // Channel outputs
   // ***************************************************************
   genvar gch;
   generate
      for (gch = 0; gch < NUM_CH; gch++)
      begin : g_chan
         // Level follows the counter; 00h wins so it never goes high.
         // FFh never matches since the counter wraps after 254.
         always_ff @(posedge core_clk_i or negedge resetn_i)
         begin
            if (!resetn_i)
               level_reg[gch] <= 1'b0;
            else if (power_down_i)
               level_reg[gch] <= level_reg[gch];
            else if (cmp_reg[gch] == CMP_LOW)
               level_reg[gch] <= 1'b0;
            // high at zero, also while cleared
            else if (cnt_reg == CNT_ZERO)
               level_reg[gch] <= 1'b1;
            else if (cnt_reg == cmp_reg[gch])
               level_reg[gch] <= 1'b0;
         end

         // Pin drive follows its own enable only
         always_ff @(posedge core_clk_i or negedge resetn_i)
         begin
            if (!resetn_i)
               oe_reg[gch] <= 1'b0;
            else
               oe_reg[gch] <= ctrl_reg.pin_drive_enable[gch];
         end
      end
   endgenerate

   assign pwm_pin_o    = level_reg;
   assign pwm_pin_oe_o = oe_reg;
   assign prdata_o     = prdata_reg;
   assign pready_o     = pready_reg;
   assign pslverr_o    = pslverr_reg;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   a_clear_reload: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      (!power_down_i && !ctrl_reg.counter_enable_clear_n)
      |=> presc_reg == ~$past(reload_reg))
      else $error("prescaler not reloaded while cleared");

   a_reload_read: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      (rd_setup && apb_req_i.paddr == OFS_RELOAD)
      |=> prdata_reg == {24'h000000, $past(reload_reg)})
      else $error("reload readback wrong");

   a_counter_range: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      cnt_reg <= CNT_MAX)
      else $error("counter beyond 254");

   a_counter_hold: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      (ctrl_reg.counter_enable_clear_n && presc_reg != PRESC_WRAP)
      |=> $stable(cnt_reg))
      else $error("counter moved before prescaler wrap");

   a_low_on_match: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      (!power_down_i && cnt_reg != CNT_ZERO
       && cnt_reg == cmp_reg[0])
      |=> !level_reg[0])
      else $error("channel 0 not low on match");

   a_high_at_zero: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      (!power_down_i && cnt_reg == CNT_ZERO
       && cmp_reg[NUM_CH-1] != CMP_LOW)
      |=> level_reg[NUM_CH-1])
      else $error("channel 1 not high at zero");

   a_zero_holds: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      (!power_down_i && cmp_reg[0] == CMP_LOW) |=> !level_reg[0])
      else $error("compare 00h output not low");

   a_full_holds: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      (cmp_reg[NUM_CH-1] == CMP_HIGH && level_reg[NUM_CH-1]
       && $stable(cmp_reg[NUM_CH-1]))
      |=> level_reg[NUM_CH-1])
      else $error("compare FFh output dropped");

   a_power_freeze: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      power_down_i |=> $stable(cnt_reg) && $stable(presc_reg)
                       && $stable(level_reg))
      else $error("state moved in power-down");

   a_clear_counter: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      (!power_down_i && !ctrl_reg.counter_enable_clear_n)
      |=> cnt_reg == CNT_ZERO)
      else $error("counter not cleared");

   a_pin_release: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      !ctrl_reg.pin_drive_enable[0] |=> !pwm_pin_oe_o[0])
      else $error("pin 0 still driven");

   a_wrap_flag: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      wrap |=> cnt_reg == CNT_ZERO && ctrl_reg.counter_overflow_flag)
      else $error("overflow not flagged");

   a_flag_sticky: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      (ctrl_reg.counter_overflow_flag
       && !(wr_en && apb_req_i.paddr == OFS_CONTROL))
      |=> ctrl_reg.counter_overflow_flag)
      else $error("overflow flag cleared by hardware");

   a_tick_spacing: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      tick |=> !tick)
      else $error("prescaler advanced on consecutive clocks");

endmodule

// ==== tb_top.sv ====
// Self-checking bench for the dual channel modulator over its APB port
`timescale 1ns/1ps

module tb_top;
   import pwm_pkg::*;

   // ***************************************************************
   // Bench constants and signals
   // ***************************************************************
   localparam int RLD = 1;                // Prescaler reload used below
   localparam int PER = 510 * (RLD + 1);  // Clocks in one output period
   localparam int STP = 2 * (RLD + 1);    // Clocks per counter step

   logic                 core_clk_i;
   logic                 resetn_i;
   logic                 power_down_i;
   apb_req_s             apb_req_i;
   logic [DATA_W-1:0]    prdata_o;
   logic                 pready_o;
   logic                 pslverr_o;
   logic [NUM_CH-1:0]    pwm_pin_o;
   logic [NUM_CH-1:0]    pwm_pin_oe_o;
   int                   err_total;
   int                   cmp_count;
   int                   h0;
   int                   h1;
   logic                 snap;

   dual_channel_pwm_unit u_dual_channel_pwm_unit
   (
      .core_clk_i   (core_clk_i),
      .resetn_i     (resetn_i),
      .power_down_i (power_down_i),
      .apb_req_i    (apb_req_i),
      .prdata_o     (prdata_o),
      .pready_o     (pready_o),
      .pslverr_o    (pslverr_o),
      .pwm_pin_o    (pwm_pin_o),
      .pwm_pin_oe_o (pwm_pin_oe_o)
   );

   // 25 MHz clock
   initial core_clk_i = 1'b0;
   always #20 core_clk_i = ~core_clk_i;

   // ***************************************************************
   // Shared tasks
   // ***************************************************************
   // Compare and count; four-state match so X never passes
   task automatic check(input string nm, input logic [31:0] exp,
                        input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One APB transfer; pready and the answer are taken at a rising edge
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] r, output logic e);
      int n;
      n = 0;
      @(posedge core_clk_i);
      apb_req_i <= '{1'b1, 1'b0, wr, a, d};
      @(posedge core_clk_i);
      apb_req_i.penable <= 1'b1;
      // Request stands until the edge at which pready is seen high
      do
      begin
         @(posedge core_clk_i);
         n++;
      end
      while (pready_o !== 1'b1 && n < 50);
      check("pready", 32'h1, {31'h0, pready_o});
      r = prdata_o;
      e = pslverr_o;
      apb_req_i.psel    <= 1'b0;
      apb_req_i.penable <= 1'b0;
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic ee);
      logic [31:0] r;
      logic        e;
      xfer(1'b1, a, d, r, e);
      check("write pslverr", {31'h0, ee}, {31'h0, e});
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x,
                     input logic ee, input string nm);
      logic [31:0] r;
      logic        e;
      xfer(1'b0, a, 32'h0, r, e);
      check(nm, x, r);
      check("read pslverr", {31'h0, ee}, {31'h0, e});
   endtask

   // Let a period settle, then count high clocks over one full period
   task automatic count_high();
      h0 = 0;
      h1 = 0;
      repeat (PER + 80) @(posedge core_clk_i);
      repeat (PER)
      begin
         @(negedge core_clk_i);
         h0 += (pwm_pin_o[0] === 1'b1);
         h1 += (pwm_pin_o[1] === 1'b1);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Watchdog sized well above the expected run of about 13000 clocks
   initial
   begin
      repeat (40000) @(posedge core_clk_i);
      err_total++;
      $display("mismatch watchdog expected done seen timeout");
      finish_test();
   end

   // ***************************************************************
   // Test sequence
   // ***************************************************************
   initial
   begin
      apb_req_i    = '0;
      power_down_i = 1'b0;
      resetn_i     = 1'b0;
      err_total    = 0;
      cmp_count    = 0;
      repeat (16) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      // Reset state, unmapped access refused
      @(negedge core_clk_i);
      check("pins", 32'h0, {30'h0, pwm_pin_o});
      check("pin enables", 32'h0, {30'h0, pwm_pin_oe_o});
      rd(OFS_CONTROL, 32'h0, 1'b0, "control");
      rd(OFS_RELOAD, 32'h0, 1'b0, "reload");
      rd(OFS_CMP0, 32'h0, 1'b0, "compare ch0");
      rd(OFS_CMP1, 32'h0, 1'b0, "compare ch1");
      wr(8'hB8, 32'h000000FF, 1'b1);
      rd(8'hCC, 32'h0, 1'b1, "unmapped");
      rd(OFS_CONTROL, 32'h0, 1'b0, "control");
      $display("test reset done");

      // Counter alone with pins released, then flag and clear
      wr(OFS_RELOAD, 32'hFFFFFF01, 1'b0);
      rd(OFS_RELOAD, 32'h00000001, 1'b0, "reload");
      wr(OFS_CMP0, 32'h00000040, 1'b0);
      wr(OFS_CMP1, 32'h000000FF, 1'b0);
      wr(OFS_CONTROL, 32'h00000004, 1'b0);
      repeat (2) @(negedge core_clk_i);
      check("pin enables", 32'h0, {30'h0, pwm_pin_oe_o});
      repeat (PER + 80) @(posedge core_clk_i);
      rd(OFS_CONTROL, 32'h0000000C, 1'b0, "control");
      wr(OFS_CONTROL, 32'h00000003, 1'b0);
      rd(OFS_CONTROL, 32'h00000003, 1'b0, "control");
      wr(OFS_CONTROL, 32'h0000000B, 1'b0);
      rd(OFS_CONTROL, 32'h00000003, 1'b0, "control");
      repeat (3) @(negedge core_clk_i);
      check("pins cleared", 32'h3, {30'h0, pwm_pin_o});
      check("pin enables", 32'h3, {30'h0, pwm_pin_oe_o});
      $display("test flag done");

      // Duty cycle and period at several compare values
      wr(OFS_CONTROL, 32'h00000007, 1'b0);
      count_high();
      check("high ch0", STP * 32'h40, h0);
      check("high ch1", PER, h1);
      wr(OFS_CMP0, 32'h00000000, 1'b0);
      count_high();
      check("high ch0", 32'h0, h0);
      wr(OFS_CMP0, 32'h000000FE, 1'b0);
      count_high();
      check("high ch0", STP * 32'hFE, h0);
      $display("test duty done");

      // Freeze and resume
      wr(OFS_CMP0, 32'h00000080, 1'b0);
      repeat (PER + 80) @(posedge core_clk_i);
      power_down_i <= 1'b1;
      repeat (3) @(negedge core_clk_i);
      snap = pwm_pin_o[0];
      count_high();
      check("frozen ch0", snap ? PER : 0, h0);
      @(posedge core_clk_i);
      power_down_i <= 1'b0;
      count_high();
      check("high ch0", STP * 32'h80, h0);
      $display("test freeze done");

      // Reset in mid-run
      @(posedge core_clk_i);
      resetn_i <= 1'b0;
      repeat (3) @(negedge core_clk_i);
      check("pins", 32'h0, {30'h0, pwm_pin_o});
      check("pin enables", 32'h0, {30'h0, pwm_pin_oe_o});
      @(posedge core_clk_i);
      resetn_i <= 1'b1;
      rd(OFS_CONTROL, 32'h0, 1'b0, "control");
      rd(OFS_CMP0, 32'h0, 1'b0, "compare ch0");
      rd(OFS_RELOAD, 32'h0, 1'b0, "reload");
      $display("test second reset done");
      finish_test();
   end

endmodule
